// ==== hw/mcc_main_clock_control.sv ====
// Behaviour
// - Bit 1 drives clock out on pin
// - Control reads zero after reset, bits writable
// - Bit 0 selects oscillator or divide by 32
// - Trim register read/write, all ones at reset
// - Trim zero fastest, all ones slowest
// - PLL output held until startup delay
// - Lock flag set, then stabilization time
// - Halt exit waits 256 CPU cycles
// - Halt stops the main oscillator
`timescale 1ns/1ps
module mcc_main_clock_control #(
  parameter int unsigned STARTUP_CYC = mcc_pkg::PLL_STARTUP_CYC,
  parameter int unsigned STAB_CYC    = mcc_pkg::PLL_STAB_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Power mode requests
  input  wire logic       halt_request,
  input  wire logic       wake_interrupt,
  input  wire logic       auto_wakeup,
  // PLL analog status
  input  wire logic       pll_at_freq,
  // Clock outputs
  output logic            cpu_clk_tick,
  output logic            cpu_run,
  output logic            osc_enable,
  output logic            pll_clk_enable,
  output logic            pll_lock_flag,
  output logic            pll_stable,
  output logic      [7:0] trim_code,
  // Clock out pin
  output logic            mco_out,
  output logic            mco_oe,
  // Interrupt
  output logic            irq
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic                    ctrl_slow;
    logic                    ctrl_mco;
    logic [7:0]              trim;
    logic [mcc_pkg::EV_N-1:0] int_status;
    logic [mcc_pkg::EV_N-1:0] int_mask;
    logic [7:0]              rdata;
    logic                    irq;
    mcc_pkg::mcc_halt_t      hstate;
    logic [7:0]              hcnt;
    mcc_pkg::mcc_pll_t       pstate;
    logic [15:0]             pcnt;
    logic                    lock;
    logic                    stable;
    logic                    pll_en;
    logic                    sync1;
    logic                    sync2;
    logic                    run;
    logic                    osc_en;
    logic                    mco_oe;
    logic                    mco_out;
  } mcc_state_t;

  localparam mcc_state_t S_RESET = '{
    ctrl_slow:  1'b0,
    ctrl_mco:   1'b0,
    trim:       mcc_pkg::TRIM_RESET,
    int_status: mcc_pkg::INT_RESET,
    int_mask:   mcc_pkg::INT_RESET,
    rdata:      8'h00,
    irq:        1'b0,
    hstate:     mcc_pkg::HS_STAB,
    hcnt:       8'h00,
    pstate:     mcc_pkg::PS_START,
    pcnt:       16'h0000,
    lock:       1'b0,
    stable:     1'b0,
    pll_en:     1'b0,
    sync1:      1'b0,
    sync2:      1'b0,
    run:        1'b0,
    osc_en:     1'b1,
    mco_oe:     1'b0,
    mco_out:    1'b0
  };

  localparam logic [15:0] STARTUP_LAST = 16'(STARTUP_CYC - 1);
  localparam logic [15:0] STAB_LAST    = 16'(STAB_CYC - 1);

  mcc_state_t s_reg;
  mcc_state_t s_next;

  logic                     div_tick;
  logic                     div_level;
  logic                     halt_entry;
  logic                     wake_exit;
  logic [mcc_pkg::EV_N-1:0] ev;
  logic [mcc_pkg::EV_N-1:0] clr;
  logic [7:0]               rd_value;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  // ************************************************************
  // CPU clock divider
  // ************************************************************
  mcc_cpu_divider u_div (
    .clk         (clk),
    .resetn      (resetn),
    .slow_select (s_reg.ctrl_slow),
    .cpu_tick    (div_tick),
    .cpu_level   (div_level),
    .slow_active ()
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_next     = s_reg;
    ev         = '0;
    clr        = '0;
    rd_value   = 8'h00;
    halt_entry = (s_reg.hstate == mcc_pkg::HS_RUN) && halt_request;
    wake_exit  = (s_reg.hstate == mcc_pkg::HS_HALT) &&
                 (wake_interrupt || auto_wakeup);

    // PLL status pin crosses in through two flops
    s_next.sync1 = pll_at_freq;
    s_next.sync2 = s_reg.sync1;

    // Register writes; upper control bits are not stored
    if (reg_wr && hit(reg_addr, mcc_pkg::OFF_CTRL)) begin
      s_next.ctrl_slow = reg_wdata[mcc_pkg::CTRL_SLOW_BIT];
      s_next.ctrl_mco  = reg_wdata[mcc_pkg::CTRL_MCO_BIT];
    end
    if (reg_wr && hit(reg_addr, mcc_pkg::OFF_TRIM)) begin
      s_next.trim = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, mcc_pkg::OFF_INT_STATUS)) begin
      clr = reg_wdata[mcc_pkg::EV_N-1:0];
    end
    if (reg_wr && hit(reg_addr, mcc_pkg::OFF_INT_MASK)) begin
      s_next.int_mask = reg_wdata[mcc_pkg::EV_N-1:0];
    end

    // Power mode sequencing
    unique case (s_reg.hstate)
      mcc_pkg::HS_STAB: begin
        if (div_tick) begin
          s_next.hcnt = s_reg.hcnt + 8'h01;
          if (s_reg.hcnt == mcc_pkg::OSC_STAB_LAST) begin
            s_next.hstate = mcc_pkg::HS_RUN;
          end
        end
      end
      mcc_pkg::HS_RUN: begin
        if (halt_entry) begin
          s_next.hstate = mcc_pkg::HS_HALT;
        end
      end
      mcc_pkg::HS_HALT: begin
        if (wake_exit) begin
          s_next.hstate = mcc_pkg::HS_STAB;
          s_next.hcnt   = 8'h00;
          ev[mcc_pkg::EV_WAKE] = 1'b1;
        end
      end
      // Unused code: settle again rather than run unclocked
      default: begin
        s_next.hstate = mcc_pkg::HS_STAB;
      end
    endcase

    // PLL start-up, lock and settling
    if (halt_entry) begin
      s_next.pstate = mcc_pkg::PS_OFF;
      s_next.pll_en = 1'b0;
      s_next.lock   = 1'b0;
      s_next.stable = 1'b0;
    end else if (wake_exit) begin
      s_next.pstate = mcc_pkg::PS_START;
      s_next.pcnt   = 16'h0000;
    end else begin
      unique case (s_reg.pstate)
        mcc_pkg::PS_OFF: begin
          s_next.pll_en = 1'b0;
        end
        mcc_pkg::PS_START: begin
          s_next.pcnt = s_reg.pcnt + 16'h0001;
          if (s_reg.pcnt == STARTUP_LAST) begin
            s_next.pstate = mcc_pkg::PS_LOCK;
            s_next.pll_en = 1'b1;
          end
        end
        mcc_pkg::PS_LOCK: begin
          // Lock is only believed once the output is running
          if (s_reg.sync2) begin
            s_next.pstate = mcc_pkg::PS_STAB;
            s_next.lock   = 1'b1;
            s_next.pcnt   = 16'h0000;
            ev[mcc_pkg::EV_LOCK] = 1'b1;
          end
        end
        mcc_pkg::PS_STAB: begin
          s_next.pcnt = s_reg.pcnt + 16'h0001;
          if (s_reg.pcnt == STAB_LAST) begin
            s_next.pstate = mcc_pkg::PS_READY;
            s_next.stable = 1'b1;
            ev[mcc_pkg::EV_STABLE] = 1'b1;
          end
        end
        mcc_pkg::PS_READY: begin
          s_next.stable = 1'b1;
        end
        default: begin
          s_next.pstate = mcc_pkg::PS_OFF;
        end
      endcase
    end

    // Sticky events; a new event beats a same-cycle clear
    s_next.int_status = (s_reg.int_status & ~clr) | ev;
    s_next.irq        = |(s_next.int_status & s_next.int_mask);

    // Pin and mode outputs, registered
    s_next.osc_en  = (s_next.hstate != mcc_pkg::HS_HALT);
    s_next.run     = (s_next.hstate == mcc_pkg::HS_RUN);
    s_next.mco_oe  = s_next.ctrl_mco;
    s_next.mco_out = s_next.ctrl_mco & div_level;

    // Register reads; unmapped addresses read zero
    if (hit(reg_addr, mcc_pkg::OFF_CTRL)) begin
      rd_value = {6'h00, s_reg.ctrl_mco, s_reg.ctrl_slow};
    end else if (hit(reg_addr, mcc_pkg::OFF_TRIM)) begin
      rd_value = s_reg.trim;
    end else if (hit(reg_addr, mcc_pkg::OFF_INT_STATUS)) begin
      rd_value = {5'h00, s_reg.int_status};
    end else if (hit(reg_addr, mcc_pkg::OFF_INT_MASK)) begin
      rd_value = {5'h00, s_reg.int_mask};
    end else if (hit(reg_addr, mcc_pkg::OFF_PLL_STATUS)) begin
      rd_value = {4'h0, (s_reg.hstate == mcc_pkg::HS_HALT),
                  s_reg.pll_en, s_reg.stable, s_reg.lock};
    end
    s_next.rdata = reg_rd ? rd_value : 8'h00;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= S_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign reg_rdata      = s_reg.rdata;
  assign cpu_clk_tick   = div_tick;
  assign cpu_run        = s_reg.run;
  assign osc_enable     = s_reg.osc_en;
  assign pll_clk_enable = s_reg.pll_en;
  assign pll_lock_flag  = s_reg.lock;
  assign pll_stable     = s_reg.stable;
  assign trim_code      = s_reg.trim;
  assign mco_out        = s_reg.mco_out;
  assign mco_oe         = s_reg.mco_oe;
  assign irq            = s_reg.irq;

  // ************************************************************
  // Checks
  // ************************************************************
  mco_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    reg_wr && reg_addr == 8'h38 |=>
      mco_oe == $past(reg_wdata[1]) && (mco_oe || !mco_out))
    else $error("Clock out pin not following control bit");

  ctrl_read_a: assert property (@(posedge clk) disable iff (!resetn)
    reg_rd && reg_addr == 8'h38 |=>
      reg_rdata[7:2] == 6'h00 && reg_rdata[1] == mco_oe ##1
      reg_rdata == 8'h00 || $past(reg_rd))
    else $error("Control read wrong or held too long");

  trim_write_a: assert property (@(posedge clk) disable iff (!resetn)
    reg_wr && reg_addr == 8'h39 |=> trim_code == $past(reg_wdata))
    else $error("Trim code not loaded");

  osc_stab_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(cpu_run) |-> $past(s_reg.hcnt) == 8'hff &&
      $past(s_reg.hstate) == mcc_pkg::HS_STAB)
    else $error("CPU released before 256 cycles");

  halt_osc_a: assert property (@(posedge clk) disable iff (!resetn)
    cpu_run && halt_request |=>
      !osc_enable && !pll_clk_enable && !cpu_run && !pll_lock_flag)
    else $error("Oscillator still on in halt");

  pll_startup_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(pll_clk_enable) |-> $past(s_reg.pcnt) == STARTUP_LAST)
    else $error("PLL clock released early");

  lock_flag_a: assert property (@(posedge clk) disable iff (!resetn)
    s_reg.pstate == mcc_pkg::PS_LOCK && s_reg.sync2 && !halt_entry &&
      !wake_exit |=> pll_lock_flag && !pll_stable &&
      s_reg.int_status[mcc_pkg::EV_LOCK])
    else $error("Lock flag or event missing");

  irq_level_a: assert property (@(posedge clk) disable iff (!resetn)
    irq == |(s_reg.int_status & s_reg.int_mask))
    else $error("Interrupt level disagrees with status");

  read_idle_a: assert property (@(posedge clk)
    disable iff (!resetn)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("Read data outside its one cycle slot");

  wake_restart_a: assert property (@(posedge clk)
    disable iff (!resetn)
    wake_exit |=> osc_enable && !cpu_run && !pll_clk_enable &&
      s_reg.int_status[mcc_pkg::EV_WAKE])
    else $error("Wake from halt did not restart the clock");

  stable_delay_a: assert property (@(posedge clk)
    disable iff (!resetn)
    $rose(pll_stable) |-> $past(s_reg.pcnt) == STAB_LAST && pll_lock_flag)
    else $error("PLL stable flag raised early");

endmodule : mcc_main_clock_control

// ==== hw/mcc_pkg.sv ====
package mcc_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] OFF_CTRL       = 8'h38;
  localparam logic [7:0] OFF_TRIM       = 8'h39;
  localparam logic [7:0] OFF_INT_STATUS = 8'h3a;
  localparam logic [7:0] OFF_INT_MASK   = 8'h3b;
  localparam logic [7:0] OFF_PLL_STATUS = 8'h3c;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int unsigned   CTRL_SLOW_BIT = 0;
  localparam int unsigned   CTRL_MCO_BIT  = 1;
  localparam logic [7:0]    CTRL_RESET    = 8'h00;
  localparam logic [7:0]    TRIM_RESET    = 8'hff;
  localparam int unsigned   EV_LOCK       = 0;
  localparam int unsigned   EV_STABLE     = 1;
  localparam int unsigned   EV_WAKE       = 2;
  localparam int unsigned   EV_N          = 3;
  localparam logic [2:0]    INT_RESET     = 3'h0;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned   CLK_PERIOD_NS      = 50;
  localparam logic [7:0]    OSC_STAB_LAST      = 8'hff;
  localparam int unsigned   SLOW_DIV           = 32;
  localparam logic [4:0]    SLOW_DIV_LAST      = 5'(SLOW_DIV - 1);
  localparam int unsigned   PLL_STARTUP_NS     = 2000;
  localparam int unsigned   PLL_STAB_NS        = 20000;
  localparam int unsigned   PLL_STARTUP_CYC    =
    (PLL_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned   PLL_STAB_CYC       =
    (PLL_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ************************************************************
  // State types
  // ************************************************************
  typedef enum logic [1:0] {HS_STAB, HS_RUN, HS_HALT} mcc_halt_t;
  typedef enum logic [2:0] {
    PS_OFF, PS_START, PS_LOCK, PS_STAB, PS_READY
  } mcc_pll_t;

endpackage : mcc_pkg

// ==== hw/mcc_cpu_divider.sv ====
`timescale 1ns/1ps
module mcc_cpu_divider (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Mode request
  input  wire logic slow_select,
  // CPU clock
  output logic      cpu_tick,
  output logic      cpu_level,
  output logic      slow_active
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [4:0] cnt;
    logic       slow;
    logic       tick;
    logic       level;
  } mcc_div_state_t;

  localparam mcc_div_state_t S_RESET = '{
    cnt: 5'h00, slow: 1'b0, tick: 1'b0, level: 1'b0
  };

  mcc_div_state_t s_reg;
  mcc_div_state_t s_next;

  // ************************************************************
  // Divider
  // ************************************************************
  always_comb begin
    s_next     = s_reg;
    s_next.cnt = s_reg.cnt + 5'h01;
    // Slow mode starts at once with a fresh count and is left only at a period end, so no short pulse
    if (!s_reg.slow) begin
      if (slow_select) begin
        s_next.slow = 1'b1;
        s_next.cnt  = 5'h00;
      end
    end else if (s_reg.cnt == mcc_pkg::SLOW_DIV_LAST && !slow_select) begin
      s_next.slow = 1'b0;
    end
    s_next.tick  = s_next.slow ?
                   (s_next.cnt == mcc_pkg::SLOW_DIV_LAST) : 1'b1;
    s_next.level = s_next.tick ? ~s_reg.level : s_reg.level;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= S_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cpu_tick    = s_reg.tick;
  assign cpu_level   = s_reg.level;
  assign slow_active = s_reg.slow;

  // ************************************************************
  // Checks
  // ************************************************************
  slow_period_a: assert property (@(posedge clk) disable iff (!resetn)
    s_reg.slow && s_reg.tick |->
      s_reg.cnt == 5'h1f ##1 (!s_reg.tick || !s_reg.slow))
    else $error("Slow tick off its 32 cycle slot");

  switch_boundary_a: assert property (@(posedge clk)
    disable iff (!resetn)
    $fell(s_reg.slow) |-> $past(s_reg.cnt) == 5'h1f && s_reg.tick)
    else $error("Slow mode left mid period");

endmodule : mcc_cpu_divider

// ==== testbench/test_main_clock_control_trim.sv ====
`timescale 1ns/1ps
module test_main_clock_control_trim;
  // ************************************************************
  // Signals
  // ************************************************************
  // Short PLL counts keep the run brief; expectations use these
  localparam int unsigned STARTUP = 4;
  localparam int unsigned STAB    = 8;
  logic       clk;
  logic       resetn;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       halt_request;
  logic       wake_interrupt;
  logic       auto_wakeup;
  logic       pll_at_freq;
  logic       cpu_clk_tick;
  logic       cpu_run;
  logic       osc_enable;
  logic       pll_clk_enable;
  logic       pll_lock_flag;
  logic       pll_stable;
  logic [7:0] trim_code;
  logic       mco_out;
  logic       mco_oe;
  logic       irq;
  int         n_mismatch;
  int         tests_run;
  int         cyc;
  int         mark;
  int         n;
  logic [7:0] d;
  logic [7:0] code;
  logic [7:0] target;
  logic [7:0] lfsr;
  logic       prev;

  mcc_main_clock_control #(.STARTUP_CYC(STARTUP), .STAB_CYC(STAB)) dut (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .halt_request(halt_request),
    .wake_interrupt(wake_interrupt), .auto_wakeup(auto_wakeup),
    .pll_at_freq(pll_at_freq), .cpu_clk_tick(cpu_clk_tick),
    .cpu_run(cpu_run), .osc_enable(osc_enable),
    .pll_clk_enable(pll_clk_enable), .pll_lock_flag(pll_lock_flag),
    .pll_stable(pll_stable), .trim_code(trim_code), .mco_out(mco_out),
    .mco_oe(mco_oe), .irq(irq)
  );

  // ************************************************************
  // Clock, helpers and checks
  // ************************************************************
  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  function automatic logic [7:0] lfsr_next(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr_next

  function automatic logic pick(input int k);
    case (k)
      0: return cpu_run;
      1: return pll_clk_enable;
      2: return pll_lock_flag;
      3: return pll_stable;
      default: return cpu_clk_tick;
    endcase
  endfunction : pick

  task automatic finish_test();
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask : check_byte

  task automatic check_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask : check_bit

  task automatic check_count(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("unexpected at %0t: %0d cycles, wanted %0d..%0d",
               $time, got, lo, hi);
    end
  endtask : check_count

  task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : reg_read

  // Bounded wait; a hang shows up as a count out of range
  task automatic wait_until(input int k, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      #1;
      cnt++;
    end while (pick(k) !== 1'b1 && cnt < 400);
  endtask : wait_until

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1;
    mark = cyc;
  endtask : do_reset

  task automatic pulse(input int k);
    @(posedge clk);
    if (k == 0) halt_request <= 1'b1;
    else if (k == 1) wake_interrupt <= 1'b1;
    else auto_wakeup <= 1'b1;
    @(posedge clk);
    halt_request   <= 1'b0;
    wake_interrupt <= 1'b0;
    auto_wakeup    <= 1'b0;
    #1;
    mark = cyc;
  endtask : pulse

  initial begin
    #(50 * 20000);
    n_mismatch++;
    finish_test();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    clk = 1'b0; resetn = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    reg_wr = 1'b0; reg_rd = 1'b0; halt_request = 1'b0;
    wake_interrupt = 1'b0; auto_wakeup = 1'b0;
    n_mismatch = 0; tests_run = 0; cyc = 0; lfsr = 8'h4a;
    // At-frequency high early: must be ignored until the gate opens
    pll_at_freq = 1'b1;
    do_reset();
    wait_until(1, n);
    check_count(n, STARTUP, STARTUP + 2);
    check_bit(pll_lock_flag, 1'b0);
    wait_until(2, n);
    check_count(n, 1, 4);
    wait_until(3, n);
    check_count(n, STAB, STAB + 2);
    check_bit(cpu_run, 1'b0);
    reg_read(8'h38, d);
    check_byte(d, 8'h00);
    reg_read(8'h39, d);
    check_byte(d, 8'hff);
    check_byte(trim_code, 8'hff);
    check_bit(mco_oe, 1'b0);
    reg_read(8'h3c, d);
    check_byte(d, 8'h07);
    reg_read(8'h3a, d);
    check_byte(d & 8'h03, 8'h03);
    check_bit(irq, 1'b0);
    wait_until(0, n);
    check_count(cyc - mark, 256, 259);
    // Interrupt raised, masked and cleared
    reg_write(8'h3b, 8'h01);
    @(posedge clk); #1;
    check_bit(irq, 1'b1);
    reg_write(8'h3a, 8'h03);
    @(posedge clk); #1;
    check_bit(irq, 1'b0);
    reg_read(8'h3b, d);
    check_byte(d, 8'h01);
    reg_write(8'h3b, 8'h00);
    reg_write(8'h50, 8'h5a);
    reg_read(8'h50, d);
    check_byte(d, 8'h00);
    // Trim search from mid-scale toward a random target
    target = lfsr;
    for (int t = 0; t < 3; t++) begin
      code = 8'h00;
      for (int b = 7; b >= 0; b--) begin
        code[b] = 1'b1;
        reg_write(8'h39, code);
        reg_read(8'h39, d);
        check_byte(d, code);
        check_byte(trim_code, code);
        // Higher code runs slower: too slow means clear the bit
        if (~trim_code < ~target) code[b] = 1'b0;
      end
      check_byte(code, target);
      lfsr = lfsr_next(lfsr);
      target = lfsr;
    end
    // Clock out onto the shared pin
    reg_write(8'h38, 8'h02);
    @(posedge clk); #1;
    check_bit(mco_oe, 1'b1);
    prev = mco_out;
    @(posedge clk); #1;
    check_bit(mco_out, ~prev);
    reg_read(8'h38, d);
    check_byte(d, 8'h02);
    reg_write(8'h38, 8'h00);
    @(posedge clk); #1;
    check_bit(mco_oe, 1'b0);
    check_bit(mco_out, 1'b0);
    // Slow mode and the switch back at a period boundary
    reg_write(8'h38, 8'h01);
    wait_until(4, n);
    for (int i = 0; i < 2; i++) begin
      wait_until(4, n);
      check_count(n, 32, 32);
    end
    reg_write(8'h38, 8'h00);
    wait_until(4, n);
    check_count(n, 30, 30);
    wait_until(4, n);
    check_count(n, 1, 1);
    // Halt, then each wake source in turn
    for (int w = 1; w < 3; w++) begin
      pulse(0);
      check_bit(osc_enable, 1'b0);
      check_bit(cpu_run, 1'b0);
      check_bit(pll_clk_enable, 1'b0);
      reg_read(8'h3c, d);
      check_byte(d, 8'h08);
      repeat (3) @(posedge clk);
      pulse(w);
      check_bit(osc_enable, 1'b1);
      wait_until(1, n);
      check_count(n, STARTUP, STARTUP + 3);
      wait_until(0, n);
      check_count(cyc - mark, 256, 259);
      reg_write(8'h3b, 8'h04);
      @(posedge clk); #1;
      check_bit(irq, 1'b1);
      reg_write(8'h3a, 8'h07);
      @(posedge clk); #1;
      check_bit(irq, 1'b0);
      reg_write(8'h3b, 8'h00);
    end
    // Second reset in mid-run restores both registers
    reg_write(8'h38, 8'h03);
    reg_write(8'h39, lfsr);
    @(posedge clk);
    do_reset();
    reg_read(8'h38, d);
    check_byte(d, 8'h00);
    reg_read(8'h39, d);
    check_byte(d, 8'hff);
    finish_test();
  end
endmodule : test_main_clock_control_trim
